// ===== rtl/ddr_half_rate_pkg.sv
/*
 * shared constants and carrier types for the half-rate controller-to-phy block.
 * assumes one clock, 50 MHz, and a memory clock equal to that clock in this model.
 */
package ddr_half_rate_pkg;

    // ------------------------------------------------------------------
    // widths of the command carrier
    // ------------------------------------------------------------------
    localparam int CS_WIDTH = 2;
    localparam int ADDR_WIDTH = 14;
    localparam int BANK_WIDTH = 3;

    // ------------------------------------------------------------------
    // rate ratio codes
    // ------------------------------------------------------------------
    localparam int RATIO_FULL = 2;
    localparam int RATIO_HALF = 4;

    // ------------------------------------------------------------------
    // defaults and timing
    // ------------------------------------------------------------------
    localparam int DEF_MEM_WIDTH = 8;
    localparam int DEF_DQ_PER_GROUP = 8;
    localparam int DEF_WLAT = 2;
    localparam int DEF_RLAT = 15;
    localparam int RLAT_MAX = 32;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CAL_TIME_NS = 10000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_CNT_WIDTH = 16;
    localparam logic RESET_INACTIVE = 1'h1;

    // one memory clock worth of address and command
    typedef struct packed {
        logic [CS_WIDTH-1:0] cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BANK_WIDTH-1:0] bank;
        logic [ADDR_WIDTH-1:0] addr;
    } cmd_slot_type;

    localparam cmd_slot_type CMD_IDLE = '{cs_n: '1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, bank: '0, addr: '0};

    // calibration sequencer states
    typedef enum logic [2:0] {
        CAL_WAIT = 3'h1,
        CAL_RUN = 3'h2,
        CAL_DONE = 3'h4
    } cal_state_type;

endpackage : ddr_half_rate_pkg

// ===== rtl/ddr_phy_controller_half_rate_if.sv
/*
 * phy side of the half-rate controller interface: captures one controller word per
 * controller cycle and plays its slots out on the memory side, low slot first; returns
 * read data and a delayed copy of the read-in-progress vector; runs a small calibration
 * sequencer that reports write and read latency.
 * assumes clk is the memory clock; a controller cycle spans rate_ratio_param/2 clocks,
 * marked by ctl_take. each memory clock carries two data beats, low beat first.
 */
`timescale 1ns/1ps

module ddr_phy_controller_half_rate_if
    import ddr_half_rate_pkg::*;
#(
    parameter int rate_ratio_param = RATIO_HALF,
    parameter int memory_bus_width = DEF_MEM_WIDTH,
    parameter int dq_per_group = DEF_DQ_PER_GROUP,
    parameter int wlat = DEF_WLAT,
    parameter int rlat = DEF_RLAT,
    parameter int cal_cycles = CAL_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cmd_slot_type [rate_ratio_param/2-1:0] ctl_cmd,
    input wire logic [memory_bus_width*rate_ratio_param-1:0] ctl_wdata,
    input wire logic [(memory_bus_width/dq_per_group)*(rate_ratio_param/2)-1:0] ctl_wdata_valid,
    input wire logic [(memory_bus_width/dq_per_group)*(rate_ratio_param/2)-1:0] ctl_dqs_burst,
    input wire logic [(memory_bus_width/dq_per_group)*(rate_ratio_param/2)-1:0] ctl_doing_rd,
    output logic ctl_take,
    output logic [memory_bus_width*rate_ratio_param-1:0] ctl_rdata,
    output logic [(memory_bus_width/dq_per_group)*(rate_ratio_param/2)-1:0] ctl_rdata_valid,
    output logic [7:0] ctl_wlat,
    output logic [7:0] ctl_rlat,
    output logic cal_done,
    output logic config_error,
    output cmd_slot_type mem_cmd,
    output logic [2*memory_bus_width-1:0] mem_dq_out,
    output logic [memory_bus_width/dq_per_group-1:0] mem_dq_oe,
    output logic [memory_bus_width/dq_per_group-1:0] mem_dqs_oe,
    input wire logic [2*memory_bus_width-1:0] mem_dq_in
);

    // ------------------------------------------------------------------
    // derived shape
    // ------------------------------------------------------------------
    localparam int SLOTS = rate_ratio_param / 2;
    localparam int GROUPS = memory_bus_width / dq_per_group;
    localparam int LOCAL_BUS_WIDTH = memory_bus_width * rate_ratio_param;
    localparam int BEATS_WIDTH = 2 * memory_bus_width;
    localparam int CTRL_WIDTH = GROUPS * SLOTS;
    localparam logic WIDTH_BAD = (memory_bus_width % dq_per_group) != 0;
    localparam logic [7:0] WLAT_CODE = 8'(wlat);
    localparam logic [7:0] RLAT_CODE = 8'(rlat);
    localparam int RLAT_TAP = (rlat < 1) ? 0 : ((rlat > RLAT_MAX) ? RLAT_MAX - 1 : rlat - 1);

    // ------------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------------
    logic rst_meta_reg, rst_sync_n_reg;

    // async assert, clocked release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'h0;
            rst_sync_n_reg <= 1'h0;
        end
        else
        begin
            rst_meta_reg <= RESET_INACTIVE;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // slot pacing and word capture
    // ------------------------------------------------------------------
    logic slot_reg, slot_next;
    logic take_reg, take_next;
    cmd_slot_type [SLOTS-1:0] cmd_word_reg, cmd_word_next;
    logic [LOCAL_BUS_WIDTH-1:0] wdata_word_reg, wdata_word_next;
    logic [CTRL_WIDTH-1:0] wvalid_word_reg, wvalid_word_next;
    logic [CTRL_WIDTH-1:0] burst_word_reg, burst_word_next;

    // slot index selecting the controller half on the memory bus
    function automatic int slot_index(input logic s);
        slot_index = (SLOTS == 1) ? 0 : int'(s);
    endfunction : slot_index

    // capture at the last slot so every slot of the word plays out whole
    always_comb
    begin
        slot_next = (slot_index(slot_reg) == SLOTS - 1) ? 1'h0 : 1'h1;
        take_next = (slot_index(slot_next) == SLOTS - 1);
        cmd_word_next = cmd_word_reg;
        wdata_word_next = wdata_word_reg;
        wvalid_word_next = wvalid_word_reg;
        burst_word_next = burst_word_reg;
        if (take_reg)
        begin
            cmd_word_next = ctl_cmd; // either slot may carry a command
            wdata_word_next = ctl_wdata;
            wvalid_word_next = ctl_wdata_valid;
            burst_word_next = ctl_dqs_burst;
        end
    end

    // ------------------------------------------------------------------
    // calibration sequencer
    // ------------------------------------------------------------------
    cal_state_type cal_state_reg, cal_state_next;
    logic [CAL_CNT_WIDTH-1:0] cal_cnt_reg, cal_cnt_next;
    logic [7:0] wlat_reg, wlat_next;
    logic [7:0] rlat_reg, rlat_next;
    logic cal_done_reg, cal_done_next;

    // short fixed sweep, then latencies are published
    always_comb
    begin
        cal_state_next = cal_state_reg;
        cal_cnt_next = cal_cnt_reg;
        wlat_next = wlat_reg;
        rlat_next = rlat_reg;
        cal_done_next = cal_done_reg;
        unique case (cal_state_reg)
            CAL_WAIT:
            begin
                cal_state_next = CAL_RUN;
                cal_cnt_next = '0;
            end
            CAL_RUN:
            begin
                cal_cnt_next = cal_cnt_reg + CAL_CNT_WIDTH'(1);
                if (cal_cnt_reg == CAL_CNT_WIDTH'(cal_cycles - 1))
                begin
                    cal_state_next = CAL_DONE;
                    wlat_next = WLAT_CODE;
                    rlat_next = RLAT_CODE;
                    cal_done_next = 1'h1;
                end
            end
            CAL_DONE: cal_done_next = 1'h1;
        endcase
    end

    // ------------------------------------------------------------------
    // memory side drive
    // ------------------------------------------------------------------
    cmd_slot_type mem_cmd_reg, mem_cmd_next;
    logic [BEATS_WIDTH-1:0] mem_dq_out_reg, mem_dq_out_next;
    logic [GROUPS-1:0] mem_dq_oe_reg, mem_dq_oe_next;
    logic [GROUPS-1:0] mem_dqs_oe_reg, mem_dqs_oe_next;

    // low slot first, low byte first within the word
    always_comb
    begin
        int s;
        s = slot_index(slot_reg);
        mem_cmd_next = cmd_word_reg[s];
        mem_dq_out_next = wdata_word_reg[s*BEATS_WIDTH +: BEATS_WIDTH];
        for (int g = 0; g < GROUPS; g++)
        begin
            mem_dq_oe_next[g] = wvalid_word_reg[s*GROUPS + g];
            mem_dqs_oe_next[g] = burst_word_reg[s*GROUPS + g] | wvalid_word_reg[s*GROUPS + g];
        end
        if (!cal_done_reg)
        begin
            // controller traffic is held off; the sweep only touches the first chip select
            mem_cmd_next = CMD_IDLE;
            mem_cmd_next.cs_n[0] = (cal_state_reg != CAL_RUN) | slot_reg;
            mem_dq_oe_next = '0;
            mem_dqs_oe_next = '0;
        end
    end

    // ------------------------------------------------------------------
    // read return
    // ------------------------------------------------------------------
    logic [LOCAL_BUS_WIDTH-1:0] rd_word_reg, rd_word_next;
    logic [LOCAL_BUS_WIDTH-1:0] rdata_reg, rdata_next;
    logic [CTRL_WIDTH-1:0] rd_pipe_reg [RLAT_MAX];
    logic [CTRL_WIDTH-1:0] rd_pipe_next [RLAT_MAX];
    logic [CTRL_WIDTH-1:0] rvalid_reg, rvalid_next;

    // beats fill the word in bus order; valid is the read-in-progress pattern delayed
    always_comb
    begin
        int s;
        s = slot_index(slot_reg);
        rd_word_next = rd_word_reg;
        rd_word_next[s*BEATS_WIDTH +: BEATS_WIDTH] = mem_dq_in; // earlier beat, lower bits
        rdata_next = rdata_reg;
        rvalid_next = rvalid_reg;
        rd_pipe_next = rd_pipe_reg;
        if (take_reg)
        begin
            rdata_next = rd_word_next;
            rd_pipe_next[0] = ctl_doing_rd;
            for (int i = 1; i < RLAT_MAX; i++)
                rd_pipe_next[i] = rd_pipe_reg[i-1];
            // tap one short: the valid register adds the last controller cycle
            rvalid_next = (RLAT_TAP == 0) ? ctl_doing_rd : rd_pipe_reg[RLAT_TAP-1];
        end
    end

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    logic config_error_reg;

    // all state on the synchronised reset; outputs are these flops directly
    always_ff @(posedge clk or negedge rst_sync_n_reg)
    begin
        if (!rst_sync_n_reg)
        begin
            slot_reg <= 1'h0;
            take_reg <= (SLOTS == 1);
            cmd_word_reg <= {SLOTS{CMD_IDLE}};
            wdata_word_reg <= '0;
            wvalid_word_reg <= '0;
            burst_word_reg <= '0;
            cal_state_reg <= CAL_WAIT;
            cal_cnt_reg <= '0;
            wlat_reg <= '0;
            rlat_reg <= '0;
            cal_done_reg <= 1'h0;
            mem_cmd_reg <= CMD_IDLE;
            mem_dq_out_reg <= '0;
            mem_dq_oe_reg <= '0;
            mem_dqs_oe_reg <= '0;
            rd_word_reg <= '0;
            rdata_reg <= '0;
            rvalid_reg <= '0;
            rd_pipe_reg <= '{default: '0};
            config_error_reg <= 1'h0;
        end
        else
        begin
            slot_reg <= slot_next;
            take_reg <= take_next;
            cmd_word_reg <= cmd_word_next;
            wdata_word_reg <= wdata_word_next;
            wvalid_word_reg <= wvalid_word_next;
            burst_word_reg <= burst_word_next;
            cal_state_reg <= cal_state_next;
            cal_cnt_reg <= cal_cnt_next;
            wlat_reg <= wlat_next;
            rlat_reg <= rlat_next;
            cal_done_reg <= cal_done_next;
            mem_cmd_reg <= mem_cmd_next;
            mem_dq_out_reg <= mem_dq_out_next;
            mem_dq_oe_reg <= mem_dq_oe_next;
            mem_dqs_oe_reg <= mem_dqs_oe_next;
            rd_word_reg <= rd_word_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            rd_pipe_reg <= rd_pipe_next;
            config_error_reg <= WIDTH_BAD; // static shape check
        end
    end

    // ports straight from the flops above
    assign ctl_take = take_reg;
    assign ctl_rdata = rdata_reg;
    assign ctl_rdata_valid = rvalid_reg;
    assign ctl_wlat = wlat_reg;
    assign ctl_rlat = rlat_reg;
    assign cal_done = cal_done_reg;
    assign config_error = config_error_reg;
    assign mem_cmd = mem_cmd_reg;
    assign mem_dq_out = mem_dq_out_reg;
    assign mem_dq_oe = mem_dq_oe_reg;
    assign mem_dqs_oe = mem_dqs_oe_reg;

endmodule : ddr_phy_controller_half_rate_if

// ===== sim/ddr_ctl_model.sv
/* controller-side model: puts one half-rate word on the block per request.
   assumes half rate, 8-bit memory bus, one strobe group, inputs driven at the falling edge. */
`timescale 1ns/1ps

module ddr_ctl_model
    import ddr_half_rate_pkg::*;
(
    input wire logic clk,
    input wire logic ctl_take,
    output cmd_slot_type [1:0] ctl_cmd,
    output logic [31:0] ctl_wdata,
    output logic [1:0] ctl_wdata_valid,
    output logic [1:0] ctl_dqs_burst,
    output logic [1:0] ctl_doing_rd
);
    // ------------------------------------------------------------------
    // word driver
    // ------------------------------------------------------------------
    // both chip-select slots high so the memory registers nothing
    task automatic idle;
        ctl_cmd <= {CMD_IDLE, CMD_IDLE};
        ctl_wdata <= 32'h0;
        ctl_wdata_valid <= 2'h0;
        ctl_dqs_burst <= 2'h0;
        ctl_doing_rd <= 2'h0;
    endtask : idle

    initial idle();

    // holds the word across one capture edge only, so a stale word is never taken twice
    task automatic send(input cmd_slot_type c0, input cmd_slot_type c1, input logic [31:0] wd,
        input logic [1:0] wv, input logic [1:0] db, input logic [1:0] rd, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(negedge clk);
            ok = (ctl_take === 1'b1);
        end
        if (ok)
        begin
            ctl_cmd <= {c1, c0};
            ctl_wdata <= wd;
            ctl_wdata_valid <= wv;
            ctl_dqs_burst <= db;
            ctl_doing_rd <= rd;
            @(posedge clk);
            @(negedge clk);
            idle();
        end
    endtask : send
endmodule : ddr_ctl_model

// ===== sim/ddr_half_rate_monitor.sv
/* checker for the half-rate controller-to-phy block: capture rhythm, slot order, latencies.
   assumes it is bound to the block, sees only its ports, and runs a half-rate build. */
`timescale 1ns/1ps

module ddr_half_rate_monitor
    import ddr_half_rate_pkg::*;
#(
    parameter int rate_ratio_param = RATIO_HALF,
    parameter int memory_bus_width = DEF_MEM_WIDTH,
    parameter int dq_per_group = DEF_DQ_PER_GROUP,
    parameter int wlat = DEF_WLAT,
    parameter int rlat = DEF_RLAT,
    localparam int G = memory_bus_width/dq_per_group,
    localparam int VW = G*(rate_ratio_param/2)
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cmd_slot_type [rate_ratio_param/2-1:0] ctl_cmd,
    input wire logic [memory_bus_width*rate_ratio_param-1:0] ctl_wdata,
    input wire logic [VW-1:0] ctl_wdata_valid,
    input wire logic [VW-1:0] ctl_dqs_burst,
    input wire logic [VW-1:0] ctl_doing_rd,
    input wire logic ctl_take,
    input wire logic [VW-1:0] ctl_rdata_valid,
    input wire logic [7:0] ctl_wlat,
    input wire logic [7:0] ctl_rlat,
    input wire logic cal_done,
    input wire logic config_error,
    input wire cmd_slot_type mem_cmd,
    input wire logic [2*memory_bus_width-1:0] mem_dq_out,
    input wire logic [G-1:0] mem_dq_oe,
    input wire logic [G-1:0] mem_dqs_oe
);
    localparam int BW = 2*memory_bus_width;
    // returned in the rlat-th controller cycle after the one that presented it
    localparam int RV_DLY = 2*rlat;

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // words taken during calibration are dropped, so only settled captures count
    sequence s_take;
        ctl_take && cal_done && $past(cal_done);
    endsequence
    sequence s_slot0;
        ##2 mem_cmd == $past(ctl_cmd[0], 2);
    endsequence
    sequence s_slot1;
        mem_cmd == $past(ctl_cmd[1], 3);
    endsequence

    AST_TAKE_ALT: assert property (ctl_take |=> !ctl_take ##1 ctl_take)
        else $error("capture pulse does not alternate");
    AST_SLOTS: assert property (s_take |-> s_slot0 ##1 s_slot1)
        else $error("command slots out of order");
    AST_CAL_CS: assert property (!cal_done |-> mem_cmd.cs_n[1])
        else $error("second chip select used in calibration");
    AST_LAT: assert property (ctl_wlat == (cal_done ? 8'(wlat) : 8'h00) && ctl_rlat == (cal_done ? 8'(rlat) : 8'h00))
        else $error("latency report wrong");
    AST_RD_VALID: assert property (s_take |-> ##RV_DLY ctl_rdata_valid == $past(ctl_doing_rd, RV_DLY))
        else $error("read valid is not the delayed read pattern");
    AST_DQ_OE: assert property (s_take |-> ##2 mem_dq_oe == $past(ctl_wdata_valid[0 +: G], 2)
        ##1 mem_dq_oe == $past(ctl_wdata_valid[G +: G], 3))
        else $error("data drive enable wrong");
    AST_DQ_BEAT: assert property ((s_take and ctl_wdata_valid[0]) |-> ##2 mem_dq_out == $past(ctl_wdata[0 +: BW], 2))
        else $error("low write beats not first");
    AST_DQS_OE: assert property (s_take |-> ##2 mem_dqs_oe == $past(ctl_dqs_burst[0 +: G] | ctl_wdata_valid[0 +: G], 2))
        else $error("strobe enable wrong");
    AST_CFG: assert property (config_error == (memory_bus_width % dq_per_group != 0))
        else $error("width check flag wrong");
endmodule : ddr_half_rate_monitor

bind ddr_phy_controller_half_rate_if ddr_half_rate_monitor #(.rate_ratio_param(rate_ratio_param),
    .memory_bus_width(memory_bus_width), .dq_per_group(dq_per_group), .wlat(wlat), .rlat(rlat)) mon_u (
    .clk(clk), .rst_n(rst_n), .ctl_cmd(ctl_cmd), .ctl_wdata(ctl_wdata), .ctl_wdata_valid(ctl_wdata_valid),
    .ctl_dqs_burst(ctl_dqs_burst), .ctl_doing_rd(ctl_doing_rd), .ctl_take(ctl_take),
    .ctl_rdata_valid(ctl_rdata_valid), .ctl_wlat(ctl_wlat), .ctl_rlat(ctl_rlat), .cal_done(cal_done),
    .config_error(config_error), .mem_cmd(mem_cmd), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
    .mem_dqs_oe(mem_dqs_oe));

// ===== sim/ddr_phy_controller_half_rate_if_tb_top.sv
/* testbench: resets the block, waits for calibration, then runs command, write and read cases.
   assumes the controller model and the bound checker are compiled before it. */
`timescale 1ns/1ps

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("FAIL %0t got %h expected %h", $time, (a), (e)); end end

module ddr_phy_controller_half_rate_if_tb_top
    import ddr_half_rate_pkg::*;
;
    logic clk, rst_n, ctl_take, cal_done, config_error, mem_dq_oe, mem_dqs_oe;
    cmd_slot_type [1:0] ctl_cmd;
    cmd_slot_type mem_cmd;
    logic [31:0] ctl_wdata, ctl_rdata;
    logic [1:0] ctl_wdata_valid, ctl_dqs_burst, ctl_doing_rd, ctl_rdata_valid;
    logic [7:0] ctl_wlat, ctl_rlat;
    logic [15:0] mem_dq_out, mem_dq_in;
    int n_fail = 0;
    int check_count = 0;

    ddr_phy_controller_half_rate_if #(.rate_ratio_param(RATIO_HALF), .memory_bus_width(8), .dq_per_group(8),
        .wlat(2), .rlat(3), .cal_cycles(4)) dut_u (.clk(clk), .rst_n(rst_n), .ctl_cmd(ctl_cmd),
        .ctl_wdata(ctl_wdata), .ctl_wdata_valid(ctl_wdata_valid), .ctl_dqs_burst(ctl_dqs_burst),
        .ctl_doing_rd(ctl_doing_rd), .ctl_take(ctl_take), .ctl_rdata(ctl_rdata), .ctl_rdata_valid(ctl_rdata_valid),
        .ctl_wlat(ctl_wlat), .ctl_rlat(ctl_rlat), .cal_done(cal_done), .config_error(config_error),
        .mem_cmd(mem_cmd), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dqs_oe(mem_dqs_oe),
        .mem_dq_in(mem_dq_in));
    ddr_ctl_model p_u (.clk(clk), .ctl_take(ctl_take), .ctl_cmd(ctl_cmd), .ctl_wdata(ctl_wdata),
        .ctl_wdata_valid(ctl_wdata_valid), .ctl_dqs_burst(ctl_dqs_burst), .ctl_doing_rd(ctl_doing_rd));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // far-side memory: distinct beats per slot so a swapped slot shows in the word
    always @(negedge clk)
        mem_dq_in <= ctl_take ? 16'h6655 : 16'h2211;

    task automatic results;
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    // a model that never sees a capture pulse ends the run
    task automatic tx(input cmd_slot_type c0, input cmd_slot_type c1, input logic [31:0] wd,
        input logic [1:0] wv, input logic [1:0] db, input logic [1:0] rd);
        bit ok;
        p_u.send(c0, c1, wd, wv, db, rd, ok);
        if (!ok)
        begin
            n_fail++;
            results();
        end
    endtask : tx

    function automatic cmd_slot_type cmd(input logic [1:0] cs, input logic [2:0] op, input logic [13:0] a);
        return '{cs_n: cs, ras_n: op[2], cas_n: op[1], we_n: op[0], bank: 3'h2, addr: a};
    endfunction : cmd

    task automatic expect_cmd(input cmd_slot_type e);
        @(negedge clk);
        `CHK(mem_cmd, e)
    endtask : expect_cmd

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // two words with gap idle words between them, every memory slot compared
    task automatic t_pair(input int gap, input cmd_slot_type a0, a1, b0, b1);
        tx(a0, a1, 32'h0, 2'h0, 2'h0, 2'h0);
        fork
            begin
                repeat (gap) tx(CMD_IDLE, CMD_IDLE, 32'h0, 2'h0, 2'h0, 2'h0);
                tx(b0, b1, 32'h0, 2'h0, 2'h0, 2'h0);
            end
            begin
                expect_cmd(a0);
                expect_cmd(a1);
                repeat (2*gap) expect_cmd(CMD_IDLE);
                expect_cmd(b0);
                expect_cmd(b1);
            end
        join
    endtask : t_pair

    // write command, strobe lead one slot early, data wlat words after the command
    task automatic t_write(input logic [1:0] v);
        int n;
        n = 0;
        tx(CMD_IDLE, cmd(2'h2, 3'h4, 14'h0100), 32'h0, 2'h0, 2'h0, 2'h0);
        tx(CMD_IDLE, CMD_IDLE, 32'h0, 2'h0, (v == 2'h3) ? 2'h2 : 2'h0, 2'h0);
        tx(CMD_IDLE, CMD_IDLE, 32'h44332211, v, 2'h3, 2'h0);
        `CHK(mem_dqs_oe, v[0])
        while (mem_dq_oe !== 1'b1 && n < 12)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 12)
        begin
            n_fail++;
            results();
        end
        `CHK(mem_dq_out, v[0] ? 16'h2211 : 16'h4433)
        @(negedge clk);
        `CHK(mem_dq_oe, v[0])
        if (v[0])
            `CHK(mem_dq_out, 16'h4433)
    endtask : t_write

    // read pattern spread over three words comes back rlat controller cycles later
    task automatic t_read;
        logic [1:0] pat [3] = '{2'h2, 2'h3, 2'h1};
        tx(CMD_IDLE, CMD_IDLE, 32'h0, 2'h0, 2'h0, pat[0]);
        fork
            begin
                tx(cmd(2'h2, 3'h5, 14'h0100), CMD_IDLE, 32'h0, 2'h0, 2'h0, pat[1]);
                tx(CMD_IDLE, CMD_IDLE, 32'h0, 2'h0, 2'h0, pat[2]);
            end
            begin
                // look mid controller cycle m after the first word, while take is high
                @(negedge clk);
                for (int m = 1; m <= 7; m++)
                begin
                    `CHK(ctl_take, 1'b1)
                    `CHK(ctl_rdata_valid, (m >= 3 && m <= 5) ? pat[m-3] : 2'h0)
                    repeat (2) @(negedge clk);
                end
            end
        join
        `CHK(ctl_rdata, 32'h66552211)
    endtask : t_read

    initial
    begin
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int n = 0; n < 40 && cal_done !== 1'b1; n++) @(negedge clk);
        `CHK(cal_done, 1'b1)
        if (cal_done !== 1'b1) results();
        `CHK(config_error, 1'b0)
        `CHK(ctl_wlat, 8'h02)
        `CHK(ctl_rlat, 8'h03)
        `CHK($bits(ctl_rdata), 32)
        t_pair(0, cmd(2'h3, 3'h3, 14'h0AAA), cmd(2'h2, 3'h4, 14'h1555),
            cmd(2'h2, 3'h5, 14'h0123), cmd(2'h3, 3'h7, 14'h0000));
        t_pair(1, cmd(2'h2, 3'h5, 14'h0456), cmd(2'h2, 3'h5, 14'h0456),
            cmd(2'h2, 3'h5, 14'h0457), cmd(2'h2, 3'h5, 14'h0457));
        t_write(2'h3);
        t_write(2'h2);
        t_read();
        results();
    end
endmodule : ddr_phy_controller_half_rate_if_tb_top
